// File: mdua_cfg.svh
// Offsets, field positions, reset values and frame counts
`ifndef MDUA_CFG_SVH
`define MDUA_CFG_SVH
`define MDUA_OFF_CTRL 12'h000
`define MDUA_OFF_CMD 12'h004
`define MDUA_OFF_SEL 12'h008
`define MDUA_OFF_EVT 12'h00C
`define MDUA_OFF_MSET 12'h010
`define MDUA_OFF_MCLR 12'h014
`define MDUA_OFF_LINK 12'h018
`define MDUA_GO_BIT 31
`define MDUA_DIR_BIT 30
`define MDUA_ACK_BIT 29
`define MDUA_REG_HI 25
`define MDUA_REG_LO 21
`define MDUA_PHY_HI 20
`define MDUA_PHY_LO 16
`define MDUA_DATA_HI 15
`define MDUA_DATA_LO 0
`define MDUA_SRC_BIT 7
`define MDUA_IEN_BIT 6
`define MDUA_MON_HI 4
`define MDUA_MON_LO 0
`define MDUA_EN_BIT 0
`define MDUA_IDLE_BIT 1
`define MDUA_EVT_CMD 0
`define MDUA_EVT_LINK 1
`define MDUA_STAT_REG 5'h01
`define MDUA_LINK_BIT 2
`define MDUA_FRAME_BITS 7'h40
`define MDUA_RELEASE_BIT 7'h2E
`define MDUA_ACK_AT 7'h31
`define MDUA_DATA_AT 7'h32
`define MDUA_LAST_AT 7'h41
`define MDUA_PRE 32'hFFFFFFFF
`define MDUA_SOF 2'h1
`define MDUA_OP_WR 2'h1
`define MDUA_OP_RD 2'h2
`define MDUA_TA_WR 2'h2
`define MDUA_RST_WORD 32'h00000000
`endif

// File: mdua_pkg.sv
// Types shared by the management port files
package mdua_pkg;
    typedef enum logic [1:0] {SCH_IDLE, SCH_WAIT, SCH_DONE} mdua_sched_t;
    typedef enum logic {FR_IDLE, FR_RUN} mdua_frame_t;
endpackage

// File: mdua_sync.sv
// Two-flop level synchroniser
`timescale 1ns/100ps
module mdua_sync (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Level in and out
    input wire logic d,
    output logic q
);
    logic meta;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 1'b0;
            q <= 1'b0;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// File: mdua_frame.sv
// Management frame engine on the link clock
`timescale 1ns/100ps
`include "mdua_cfg.svh"
module mdua_frame (
    // Link clock and reset
    input wire logic link_clk,
    input wire logic hresetn,
    // Job handshake and fields
    input wire logic req_tog,
    input wire logic wr,
    input wire logic [4:0] phy,
    input wire logic [4:0] regi,
    input wire logic [15:0] wdata,
    output logic ack_tog,
    output logic rd_ack,
    output logic [15:0] rdata,
    // Serial data pin, input already synchronised
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe
);
    mdua_pkg::mdua_frame_t st;
    logic [6:0] cnt;
    logic [63:0] sh;
    logic wr_q;
    wire start = (st == mdua_pkg::FR_IDLE) && (req_tog != ack_tog);
    wire [6:0] nxt = cnt + 7'h01;
    wire [1:0] op = wr ? `MDUA_OP_WR : `MDUA_OP_RD;
    wire [1:0] ta = wr ? `MDUA_TA_WR : 2'h3;
    wire [15:0] dat = wr ? wdata : 16'hFFFF;
    // see (R15)
    wire [63:0] word = {`MDUA_PRE, `MDUA_SOF, op, phy, regi, ta, dat};
    // Read side releases the pin from the turnaround on
    wire drive = (nxt < `MDUA_FRAME_BITS) &&
        (wr_q || nxt < `MDUA_RELEASE_BIT);

    always_ff @(posedge link_clk or negedge hresetn) begin
        if (!hresetn) begin
            st <= mdua_pkg::FR_IDLE;
            cnt <= 7'h00;
            sh <= 64'h0000000000000000;
            wr_q <= 1'b0;
            ack_tog <= 1'b0;
            rd_ack <= 1'b0;
            rdata <= 16'h0000;
            mdio_out <= 1'b1;
            mdio_oe <= 1'b0;
        end else begin
            case (st)
                mdua_pkg::FR_IDLE: begin
                    if (start) begin
                        sh <= word;
                        cnt <= 7'h00;
                        wr_q <= wr;
                        mdio_out <= word[63];
                        mdio_oe <= 1'b1;
                        st <= mdua_pkg::FR_RUN;
                    end
                end
                mdua_pkg::FR_RUN: begin
                    cnt <= nxt;
                    sh <= {sh[62:0], 1'b1};
                    mdio_out <= drive ? sh[62] : 1'b1;
                    mdio_oe <= drive;
                    // Input lags two link clocks behind the pin
                    if (cnt == `MDUA_ACK_AT) begin
                        rd_ack <= !wr_q && !mdio_in; // see (R7)
                    end
                    if (cnt >= `MDUA_DATA_AT) begin
                        rdata <= {rdata[14:0], mdio_in}; // see (R10)
                    end
                    if (cnt == `MDUA_LAST_AT) begin
                        ack_tog <= ~ack_tog;
                        st <= mdua_pkg::FR_IDLE;
                    end
                end
                default: st <= mdua_pkg::FR_IDLE;
            endcase
        end
    end
endmodule

// File: mdua_top.sv
// Management user access port: AHB-Lite registers and job scheduler
//
// Behaviour
// (R1) Start bit queues a job, run later
// (R2) Writing zero to start changes nothing
// (R3) Start settable only while machine enabled
// (R4) Start bit self-clears when job finishes
// (R5) Command writes discarded while start reads one
// (R6) Direction bit one writes, zero reads
// (R7) Acknowledge flag set when PHY acknowledged read
// (R8) Bits 25:21 give PHY register address
// (R9) Bits 20:16 give target PHY address
// (R10) Bits 15:0 write data, read result
// (R11) Link source bit resets zero, unused
// (R12) Link change event only when enabled
// (R13) Bits 4:0 pick monitored PHY address
// (R14) Command done event, mask set/clear
// (R15) Standard management frame on the pin
// (R16) Ack and data updated before start clears
//
// The AHB-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/100ps
`include "mdua_cfg.svh"
module mdua_top (
    // AHB-Lite clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Link clock and serial data pin
    input wire logic link_clk,
    input wire logic mdio_in,
    output logic mdio_out,
    output logic mdio_oe,
    // Event outputs
    output logic cmd_done_irq,
    output logic link_change_irq
);
    function automatic logic hit(input logic [11:0] a,
                                 input logic [11:0] o);
        hit = (a[11:2] == o[11:2]);
    endfunction

    // Bus address phase capture
    logic a_valid;
    logic a_wr;
    logic [11:0] a_off;

    // Control and command register
    logic enable;
    logic cmd_go;
    logic cmd_wr;
    logic cmd_ack;
    logic [4:0] cmd_reg;
    logic [4:0] cmd_phy;
    logic [15:0] cmd_data;

    // Link monitor select register and link state
    logic link_status_source;
    logic link_change_irq_enable;
    logic [4:0] monitored_device_index;
    logic link_up;

    // Events and mask
    logic evt_cmd;
    logic evt_link;
    logic [1:0] mask;

    // Scheduler and job fields handed to the link side
    mdua_pkg::mdua_sched_t st;
    logic job_user;
    logic req_tog;
    logic j_wr;
    logic [4:0] j_phy;
    logic [4:0] j_reg;
    logic [15:0] j_data;

    // Crossing signals
    logic req_l;
    logic ack_tog_l;
    logic ack_h;
    logic mdio_in_l;
    logic f_ack;
    logic [15:0] f_data;

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    wire xfer = hsel && htrans[1] && hready;
    wire wr_ph = a_valid && a_wr;
    wire wr_ctrl = wr_ph && hit(a_off, `MDUA_OFF_CTRL);
    wire wr_cmd = wr_ph && hit(a_off, `MDUA_OFF_CMD);
    wire wr_sel = wr_ph && hit(a_off, `MDUA_OFF_SEL);
    wire wr_evt = wr_ph && hit(a_off, `MDUA_OFF_EVT);
    wire wr_mset = wr_ph && hit(a_off, `MDUA_OFF_MSET);
    wire wr_mclr = wr_ph && hit(a_off, `MDUA_OFF_MCLR);

    // Read decode of the address phase
    wire [11:0] r_off = haddr[11:0];
    wire idle = (st == mdua_pkg::SCH_IDLE);
    wire [31:0] rd_ctrl = {30'h00000000, idle, enable};
    wire [31:0] rd_cmd = {cmd_go, cmd_wr, cmd_ack, 3'h0, cmd_reg,
                          cmd_phy, cmd_data};
    wire [31:0] rd_sel = {24'h000000, link_status_source,
                          link_change_irq_enable, 1'b0,
                          monitored_device_index};
    wire [31:0] rd_evt = {30'h00000000, evt_link, evt_cmd};
    wire [31:0] rd_mask = {30'h00000000, mask};
    wire [31:0] rd_link = {31'h00000000, link_up};
    wire [31:0] rd_mux =
        hit(r_off, `MDUA_OFF_CTRL) ? rd_ctrl :
        hit(r_off, `MDUA_OFF_CMD) ? rd_cmd :
        hit(r_off, `MDUA_OFF_SEL) ? rd_sel :
        hit(r_off, `MDUA_OFF_EVT) ? rd_evt :
        hit(r_off, `MDUA_OFF_MSET) ? rd_mask :
        hit(r_off, `MDUA_OFF_MCLR) ? rd_mask :
        hit(r_off, `MDUA_OFF_LINK) ? rd_link : `MDUA_RST_WORD;

    // Job completion, seen once the returned toggle matches
    wire job_done = (st == mdua_pkg::SCH_WAIT) && (ack_h == req_tog);
    wire user_done = job_done && job_user;
    wire poll_done = job_done && !job_user;
    wire new_link = f_ack && f_data[`MDUA_LINK_BIT];
    wire link_chg = poll_done && (new_link != link_up);

    // Command register write accepted only while the start bit is clear
    wire cmd_take = wr_cmd && !cmd_go; // see (R5)
    wire go_set = cmd_take && hwdata[`MDUA_GO_BIT] && enable;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_valid <= 1'b0;
            a_wr <= 1'b0;
            a_off <= 12'h000;
            hrdata <= `MDUA_RST_WORD;
        end else begin
            a_valid <= xfer;
            a_wr <= hwrite;
            a_off <= haddr[11:0];
            if (xfer && !hwrite) begin
                hrdata <= rd_mux;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            enable <= 1'b0;
        end else if (wr_ctrl) begin
            enable <= hwdata[`MDUA_EN_BIT];
        end
    end

    // Start bit: one write sets, hardware clears
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_go <= 1'b0;
        end else if (go_set) begin
            cmd_go <= 1'b1; // see (R1) (R2) (R3)
        end else if (st == mdua_pkg::SCH_DONE && job_user) begin
            cmd_go <= 1'b0; // see (R4)
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_wr <= 1'b0;
            cmd_ack <= 1'b0;
            cmd_reg <= 5'h00;
            cmd_phy <= 5'h00;
            cmd_data <= 16'h0000;
        end else if (cmd_take) begin
            cmd_wr <= hwdata[`MDUA_DIR_BIT];
            cmd_ack <= hwdata[`MDUA_ACK_BIT];
            cmd_reg <= hwdata[`MDUA_REG_HI:`MDUA_REG_LO]; // see (R8)
            cmd_phy <= hwdata[`MDUA_PHY_HI:`MDUA_PHY_LO]; // see (R9)
            cmd_data <= hwdata[`MDUA_DATA_HI:`MDUA_DATA_LO];
        end else if (user_done) begin
            // One cycle ahead of the start bit clearing
            cmd_ack <= f_ack; // see (R7) (R16)
            if (!cmd_wr) begin
                cmd_data <= f_data; // see (R10) (R16)
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link_status_source <= 1'b0; // see (R11)
            link_change_irq_enable <= 1'b0;
            monitored_device_index <= 5'h00;
        end else if (wr_sel) begin
            link_status_source <= hwdata[`MDUA_SRC_BIT];
            link_change_irq_enable <= hwdata[`MDUA_IEN_BIT];
            monitored_device_index <=
                hwdata[`MDUA_MON_HI:`MDUA_MON_LO]; // see (R13)
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            link_up <= 1'b0;
        end else if (poll_done) begin
            link_up <= new_link;
        end
    end

    // Sticky events: a set in the clearing cycle wins
    wire set_cmd = (st == mdua_pkg::SCH_DONE) && job_user;
    wire set_link = link_chg && link_change_irq_enable; // see (R12)
    wire clr_cmd = wr_evt && hwdata[`MDUA_EVT_CMD];
    wire clr_link = wr_evt && hwdata[`MDUA_EVT_LINK];
    wire [1:0] mset = wr_mset ? hwdata[1:0] : 2'h0;
    wire [1:0] mclr = wr_mclr ? hwdata[1:0] : 2'h0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            evt_cmd <= 1'b0;
            evt_link <= 1'b0;
            mask <= 2'h0;
            cmd_done_irq <= 1'b0;
            link_change_irq <= 1'b0;
        end else begin
            evt_cmd <= set_cmd || (evt_cmd && !clr_cmd); // see (R14)
            evt_link <= set_link || (evt_link && !clr_link);
            mask <= (mask | mset) & ~mclr; // see (R14)
            cmd_done_irq <= evt_cmd && mask[0];
            link_change_irq <= evt_link && link_change_irq_enable;
        end
    end

    // Scheduler: user command first, otherwise poll the link
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st <= mdua_pkg::SCH_IDLE;
            job_user <= 1'b0;
            req_tog <= 1'b0;
            j_wr <= 1'b0;
            j_phy <= 5'h00;
            j_reg <= 5'h00;
            j_data <= 16'h0000;
        end else begin
            case (st)
                mdua_pkg::SCH_IDLE: begin
                    if (enable) begin
                        // Pending command waits for a free engine
                        job_user <= cmd_go; // see (R1)
                        j_wr <= cmd_go && cmd_wr; // see (R6)
                        j_phy <= cmd_go ? cmd_phy :
                            monitored_device_index; // see (R13)
                        j_reg <= cmd_go ? cmd_reg : `MDUA_STAT_REG;
                        j_data <= cmd_data;
                        req_tog <= ~req_tog;
                        st <= mdua_pkg::SCH_WAIT;
                    end
                end
                mdua_pkg::SCH_WAIT: begin
                    if (job_done) begin
                        st <= mdua_pkg::SCH_DONE;
                    end
                end
                mdua_pkg::SCH_DONE: st <= mdua_pkg::SCH_IDLE;
                default: st <= mdua_pkg::SCH_IDLE;
            endcase
        end
    end

    // Job fields are held stable until the toggle returns
    mdua_sync u_req_sync (
        .clk(link_clk),
        .rst_n(hresetn),
        .d(req_tog),
        .q(req_l)
    );

    mdua_sync u_pin_sync (
        .clk(link_clk),
        .rst_n(hresetn),
        .d(mdio_in),
        .q(mdio_in_l)
    );

    mdua_sync u_ack_sync (
        .clk(hclk),
        .rst_n(hresetn),
        .d(ack_tog_l),
        .q(ack_h)
    );

    // Results stay still until the next request leaves
    mdua_frame u_frame (
        .link_clk(link_clk),
        .hresetn(hresetn),
        .req_tog(req_l),
        .wr(j_wr),
        .phy(j_phy),
        .regi(j_reg),
        .wdata(j_data),
        .ack_tog(ack_tog_l),
        .rd_ack(f_ack),
        .rdata(f_data),
        .mdio_in(mdio_in_l),
        .mdio_out(mdio_out),
        .mdio_oe(mdio_oe)
    );
endmodule

// File: mdua_phy_model.sv
// Behavioural management-bus device answering at one address
`timescale 1ns/100ps
module mdua_phy_model #(
    parameter logic [4:0] ADDR = 5'h03
) (
    // Link clock, wire level and link state
    input wire logic link_clk,
    input wire logic pin,
    input wire logic link_up,
    // Drive back onto the wire
    output logic drv = 1'h1,
    output logic drv_oe = 1'h0
);
    logic [15:0] mem [32] = '{default: 16'h0};
    logic [6:0] n = 7'h0;
    logic [5:0] ones = 6'h0;
    logic [15:0] sh = 16'h0;
    logic [4:0] ra = 5'h0;
    logic rd = 1'h0;
    logic hit = 1'h0;
    wire [15:0] rdv = ra == 5'h01 ?
        {mem[1][15:3], link_up, mem[1][1:0]} : mem[ra];
    // Idle wire is pulled high, so the ones count saturates at 32 between frames
    always @(posedge link_clk) begin
        ones <= !pin ? 6'h0 : (ones[5] ? ones : ones + 6'h1);
        if (n == 7'h0) begin
            if (!pin && ones[5])
                n <= 7'h21;
        end else begin
            sh <= {sh[14:0], pin};
            n <= n == 7'h3F ? 7'h0 : n + 7'h1;
            if (n == 7'h23)
                rd <= sh[0] && !pin;
            if (n == 7'h2D) begin
                ra <= {sh[3:0], pin};
                hit <= sh[8:4] == ADDR;
            end
            if (n == 7'h2E && rd && hit) begin
                drv_oe <= 1'h1;
                drv <= 1'h0;
            end
            if (n > 7'h2E && n < 7'h3F && rd && hit)
                drv <= rdv[4'(7'h3E - n)];
            if (n == 7'h3F) begin
                drv_oe <= 1'h0;
                drv <= 1'h1;
                if (!rd && hit)
                    mem[ra] <= {sh[14:0], pin};
            end
        end
    end
endmodule

// File: mdua_top_asserts.sv
// Port checker for the management user access port
`timescale 1ns/100ps
`include "mdua_cfg.svh"
module mdua_top_asserts (
    // Bus side
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    // Link side and events
    input wire logic link_clk,
    input wire logic mdio_out,
    input wire logic mdio_oe,
    input wire logic cmd_done_irq,
    input wire logic link_change_irq
);
    logic wr_q;
    logic [11:0] a_q;
    logic ien;
    logic mask0;
    logic [6:0] bitn;
    wire take_wr = hsel && htrans[1] && hready && hwrite;
    wire sel_wr = wr_q && a_q == `MDUA_OFF_SEL;
    wire mset = wr_q && a_q == `MDUA_OFF_MSET && hwdata[0];
    wire mclr = wr_q && a_q == `MDUA_OFF_MCLR && hwdata[0];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'h0;
            a_q <= 12'h0;
            ien <= 1'h0;
            mask0 <= 1'h0;
        end else begin
            wr_q <= take_wr;
            a_q <= haddr[11:0];
            if (sel_wr)
                ien <= hwdata[`MDUA_IEN_BIT];
            if (mset || mclr)
                mask0 <= mset;
        end
    end
    // Bit index on the wire; reads drop the drive, which restarts it
    always_ff @(posedge link_clk or negedge hresetn) begin
        if (!hresetn)
            bitn <= 7'h0;
        else
            bitn <= mdio_oe ? bitn + 7'h1 : 7'h0;
    end
    sequence rd_op_s;
        mdio_oe && bitn == 7'h22 && mdio_out ##1 !mdio_out;
    endsequence
    sequence wr_op_s;
        mdio_oe && bitn == 7'h22 && !mdio_out ##1 mdio_out;
    endsequence
    pre_ones_a: assert property (
        @(posedge link_clk) disable iff (!hresetn)
        mdio_oe && bitn < 7'h20 |-> mdio_out)
        else $error("preamble bit low");
    sof_bits_a: assert property (
        @(posedge link_clk) disable iff (!hresetn)
        mdio_oe && bitn == 7'h20 |-> !mdio_out ##1 mdio_out)
        else $error("bad start bits");
    rd_release_a: assert property (
        @(posedge link_clk) disable iff (!hresetn)
        rd_op_s |-> ##11 !mdio_oe)
        else $error("read turnaround not released");
    wr_turn_a: assert property (
        @(posedge link_clk) disable iff (!hresetn)
        wr_op_s |-> ##11 mdio_oe && mdio_out ##1 mdio_oe && !mdio_out)
        else $error("write turnaround wrong");
    idle_high_a: assert property (
        @(posedge link_clk) disable iff (!hresetn)
        !mdio_oe |-> mdio_out)
        else $error("idle drive value low");
    link_gate_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !ien [*2] |-> !link_change_irq)
        else $error("link event not gated");
    link_rise_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        $rose(link_change_irq) |-> $past(ien))
        else $error("link event rose while disabled");
    done_gate_a: assert property (
        @(posedge hclk) disable iff (!hresetn)
        !mask0 [*2] |-> !cmd_done_irq)
        else $error("done event not masked");
endmodule
bind mdua_top mdua_top_asserts i_mdua_top_asserts (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
    .link_clk(link_clk), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
    .cmd_done_irq(cmd_done_irq), .link_change_irq(link_change_irq));

// File: mdua_top_tb.sv
// Bench for the management user access port
`timescale 1ns/100ps
`include "mdua_cfg.svh"
module mdua_top_tb;
    localparam logic [4:0] PA = 5'h03;
    localparam logic [31:0] ACK_SET = 32'h20000000;
    logic hclk;
    logic link_clk;
    logic hresetn;
    logic hsel;
    logic hwrite;
    logic [1:0] htrans;
    logic [31:0] haddr;
    logic [31:0] hwdata;
    logic [31:0] hrdata;
    logic [31:0] q;
    logic hreadyout;
    logic hresp;
    logic mdio_out;
    logic mdio_oe;
    logic cmd_done_irq;
    logic link_change_irq;
    logic phy_drv;
    logic phy_oe;
    logic link_up;
    int mismatches;
    int comparisons;
    // Pulled-up shared wire
    wire pin = mdio_oe ? mdio_out : (phy_oe ? phy_drv : 1'h1);
    mdua_top i_mdua_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .link_clk(link_clk),
        .mdio_in(pin), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
        .cmd_done_irq(cmd_done_irq), .link_change_irq(link_change_irq));
    mdua_phy_model #(.ADDR(PA)) i_mdua_phy_model (.link_clk(link_clk),
        .pin(pin), .link_up(link_up), .drv(phy_drv), .drv_oe(phy_oe));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            mismatches++;
            $display("mismatch at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task automatic end_sim;
        if (mismatches == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'h1);
        q = hrdata;
    endtask
    function automatic logic [31:0] cmd(logic go, logic dir,
        logic [4:0] r, logic [4:0] p, logic [15:0] d);
        return {go, dir, 4'h0, r, p, d};
    endfunction
    // A poll may already be running ahead of a user job, so allow two frames
    task automatic wait_go;
        repeat (600) begin
            xfer(1'h0, `MDUA_OFF_CMD, 32'h0);
            if (q[31] === 1'h0)
                break;
        end
    endtask
    task automatic t_reset;
        xfer(1'h0, `MDUA_OFF_CTRL, 32'h0);
        chk(q, 32'h2);
        chk({30'h0, hresp, hreadyout}, 32'h1);
        xfer(1'h0, `MDUA_OFF_CMD, 32'h0);
        chk(q, `MDUA_RST_WORD);
        xfer(1'h0, `MDUA_OFF_SEL, 32'h0);
        chk(q, 32'h0);
        xfer(1'h0, 12'h100, 32'h0);
        chk(q, 32'h0);
    endtask
    task automatic t_off;
        xfer(1'h1, `MDUA_OFF_CMD, cmd(1'h1, 1'h0, 5'h07, PA, 16'h1234));
        xfer(1'h0, `MDUA_OFF_CMD, 32'h0);
        chk(q, cmd(1'h0, 1'h0, 5'h07, PA, 16'h1234));
    endtask
    task automatic t_write;
        xfer(1'h1, `MDUA_OFF_CTRL, 32'h1);
        xfer(1'h1, `MDUA_OFF_MSET, 32'h1);
        xfer(1'h1, `MDUA_OFF_CMD, cmd(1'h1, 1'h1, 5'h05, PA, 16'hA5C3));
        xfer(1'h0, `MDUA_OFF_CMD, 32'h0);
        chk(q, cmd(1'h1, 1'h1, 5'h05, PA, 16'hA5C3));
        xfer(1'h1, `MDUA_OFF_CMD, cmd(1'h0, 1'h0, 5'h09, 5'h1C, 16'h0F0F));
        xfer(1'h0, `MDUA_OFF_CMD, 32'h0);
        chk(q, cmd(1'h1, 1'h1, 5'h05, PA, 16'hA5C3));
        wait_go;
        chk(q, cmd(1'h0, 1'h1, 5'h05, PA, 16'hA5C3));
        chk({16'h0, i_mdua_phy_model.mem[5]}, 32'hA5C3);
        chk({31'h0, cmd_done_irq}, 32'h1);
        xfer(1'h1, `MDUA_OFF_EVT, 32'h1);
        repeat (2) @(posedge hclk);
        chk({31'h0, cmd_done_irq}, 32'h0);
    endtask
    task automatic t_read;
        // Closed mask keeps the done event off the output
        xfer(1'h1, `MDUA_OFF_MCLR, 32'h1);
        xfer(1'h1, `MDUA_OFF_CMD, cmd(1'h1, 1'h0, 5'h05, PA, 16'h0));
        wait_go;
        chk(q, cmd(1'h0, 1'h0, 5'h05, PA, 16'hA5C3) | ACK_SET);
        chk({31'h0, cmd_done_irq}, 32'h0);
        xfer(1'h1, `MDUA_OFF_MSET, 32'h1);
        repeat (2) @(posedge hclk);
        chk({31'h0, cmd_done_irq}, 32'h1);
        xfer(1'h1, `MDUA_OFF_CMD, cmd(1'h1, 1'h0, 5'h02, 5'h11, 16'h0));
        wait_go;
        chk({31'h0, q[29]}, 32'h0);
    endtask
    task automatic t_link;
        xfer(1'h1, `MDUA_OFF_SEL, {24'h0, 2'h1, 1'h0, PA});
        xfer(1'h0, `MDUA_OFF_SEL, 32'h0);
        chk(q, {24'h0, 2'h1, 1'h0, PA});
        link_up <= 1'h1;
        repeat (3000) begin
            @(posedge hclk);
            if (link_change_irq === 1'h1)
                break;
        end
        chk({31'h0, link_change_irq}, 32'h1);
        xfer(1'h0, `MDUA_OFF_LINK, 32'h0);
        chk(q, 32'h1);
        xfer(1'h1, `MDUA_OFF_SEL, {27'h0, PA});
        xfer(1'h1, `MDUA_OFF_EVT, 32'h3);
        link_up <= 1'h0;
        repeat (2500) @(posedge hclk);
        chk({31'h0, link_change_irq}, 32'h0);
        xfer(1'h0, `MDUA_OFF_EVT, 32'h0);
        chk(q & 32'h2, 32'h0);
    endtask
    initial begin
        hclk = 1'h0;
        forever #4 hclk = ~hclk;
    end
    // Offset start keeps the link clock unrelated in phase
    initial begin
        link_clk = 1'h0;
        #5;
        forever #32 link_clk = ~link_clk;
    end
    initial begin
        hresetn = 1'h0;
        hsel = 1'h0;
        htrans = 2'h0;
        hwrite = 1'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        link_up = 1'h0;
        mismatches = 0;
        comparisons = 0;
        repeat (2) @(posedge link_clk);
        @(posedge hclk);
        hresetn <= 1'h1;
        t_reset;
        t_off;
        t_write;
        t_read;
        t_link;
        end_sim;
    end
    initial begin
        repeat (30000) @(posedge hclk);
        mismatches++;
        end_sim;
    end
endmodule
